// File: src/rtcia_slave.sv
/*
  Two-wire bus slave giving register access to the clock, control and user registers.
  Assumes bus pins are asynchronous to clock; clock far faster than the bus clock.
  Register writes pass a FIFO to the register store, which is always ready and takes one each clock cycle.
*/
`timescale 1ns/1ps
`include "rtcia_defs.svh"
// Contract
// - Write: id, address, data, each acknowledged
// - After stop, return idle awaiting start
// - Acknowledge id, address, second id
// - Keep sending while master acknowledges
// - Pointer loaded from address, increments per byte
// - Pointer wraps from 13h to 00h
// - Match seven upper bits; eighth selects direction
// - All bytes most significant bit first
// - Pointer cleared to zero at reset
// - Receiver pulls data low in ninth clock
module rtcia_slave #(
  parameter logic [6:0] DEV_ID = `RTCIA_DEV_ID, // Arbitrary default
  parameter int REG_COUNT = `RTCIA_REG_COUNT
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic [7:0] regPointer,
  output logic busBusy
);
  import rtcia_pkg::*;

  logic [2:0] sclSync, sdaSync;
  logic sclPrev, sdaPrev;
  logic sclRise, sclFall, startSeen, stopSeen;
  rtcia_state_t state, next_state;
  rtcia_byte_t shiftReg, next_shiftReg;
  logic [3:0] bitCount, next_bitCount;
  logic [1:0] byteIdx, next_byteIdx;
  logic readMode, next_readMode;
  logic nackPending, next_nackPending;
  logic [7:0] pointer, next_pointer;
  logic next_sdaOe, next_busBusy;
  rtcia_byte_t regs [REG_COUNT];
  logic fifoOutValid;
  logic [15:0] fifoOutData;
  logic [15:0] next_wrData;
  logic next_wrValid, wrValid;
  logic [15:0] wrData;
  rtcia_wr_if #(.WIDTH(`RTCIA_FIFO_WIDTH)) wrBus ();

  assign wrBus.valid = wrValid;
  assign wrBus.data = wrData;

  rtcia_fifo #(.WIDTH(`RTCIA_FIFO_WIDTH), .DEPTH(`RTCIA_FIFO_DEPTH)) writeFifo (
    .clock(clock),
    .reset(reset),
    .inPort(wrBus.sink),
    .outValid(fifoOutValid),
    .outReady(1'b1),
    .outData(fifoOutData)
  );

  // Pins pass three flops; only the second and third stages are read
  always_ff @(posedge clock) begin
    if (reset) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
    end else begin
      sclSync <= {sclSync[1:0], sclIn};
      sdaSync <= {sdaSync[1:0], sdaIn};
    end
  end

  always_comb begin
    sclPrev = sclSync[2];
    sdaPrev = sdaSync[2];
    sclRise = sclSync[1] && !sclPrev;
    sclFall = !sclSync[1] && sclPrev;
    startSeen = sclSync[1] && sclPrev && sdaPrev && !sdaSync[1];
    stopSeen = sclSync[1] && sclPrev && !sdaPrev && sdaSync[1];
  end

  function automatic logic [7:0] rtcia_next_ptr(input logic [7:0] p);
    rtcia_next_ptr = (p == `RTCIA_REG_TOP) ? 8'h00 : p + 8'h01;
  endfunction

  always_comb begin
    next_state = state;
    next_shiftReg = shiftReg;
    next_bitCount = bitCount;
    next_byteIdx = byteIdx;
    next_readMode = readMode;
    next_nackPending = nackPending;
    next_pointer = pointer;
    next_sdaOe = sdaOe;
    next_busBusy = busBusy;
    next_wrValid = 1'b0;
    next_wrData = wrData;
    if (stopSeen) begin
      next_state = RTCIA_IDLE;
      next_sdaOe = 1'b0;
      next_busBusy = 1'b0;
    end else if (startSeen) begin
      // Repeated start keeps the pointer set by the dummy write
      next_state = RTCIA_RECV;
      next_bitCount = 4'h0;
      next_byteIdx = 2'h0;
      next_sdaOe = 1'b0;
      next_busBusy = 1'b1;
    end else begin
      case (state)
        RTCIA_IDLE, RTCIA_IGNORE: begin
          next_sdaOe = 1'b0;
        end
        RTCIA_RECV: begin
          if (sclRise) begin
            next_shiftReg = {shiftReg[6:0], sdaSync[1]};
            next_bitCount = bitCount + 4'h1;
          end else if (sclFall && bitCount == 4'h8) begin
            next_bitCount = 4'h0;
            next_state = RTCIA_ACK;
            next_sdaOe = 1'b1;
            next_nackPending = 1'b0;
            if (byteIdx == 2'h0) begin
              next_readMode = shiftReg[0];
              if (shiftReg[7:1] != DEV_ID) begin
                next_state = RTCIA_IGNORE;
                next_sdaOe = 1'b0;
              end
            end else if (byteIdx == 2'h1) begin
              next_pointer = shiftReg;
            end else begin
              // Data byte; a fourth byte is refused with a released ack
              if (byteIdx == 2'h2 && wrBus.ready) begin
                next_wrValid = 1'b1;
                next_wrData = {pointer, shiftReg};
                next_pointer = rtcia_next_ptr(pointer);
              end else begin
                next_sdaOe = 1'b0;
                next_nackPending = 1'b1;
              end
            end
          end
        end
        RTCIA_ACK: begin
          // Ack held through the ninth clock
          if (sclFall) begin
            next_sdaOe = 1'b0;
            if (nackPending) begin
              next_state = RTCIA_IGNORE;
            end else if (byteIdx == 2'h0 && readMode) begin
              next_state = RTCIA_SEND;
              next_shiftReg = regs[pointer[4:0]];
              next_sdaOe = !regs[pointer[4:0]][7];
              next_bitCount = 4'h1;
            end else begin
              next_state = RTCIA_RECV;
              next_byteIdx = (byteIdx == 2'h3) ? byteIdx : byteIdx + 2'h1;
            end
          end
        end
        RTCIA_SEND: begin
          if (sclFall) begin
            if (bitCount == 4'h8) begin
              next_sdaOe = 1'b0;
              next_state = RTCIA_MACK;
              next_pointer = rtcia_next_ptr(pointer);
            end else begin
              next_shiftReg = {shiftReg[6:0], 1'b0};
              next_sdaOe = !shiftReg[6];
              next_bitCount = bitCount + 4'h1;
            end
          end
        end
        RTCIA_MACK: begin
          if (sclRise) begin
            // Master ack low keeps the stream going
            next_nackPending = sdaSync[1];
          end else if (sclFall) begin
            if (nackPending) begin
              next_state = RTCIA_IGNORE;
            end else begin
              next_state = RTCIA_SEND;
              next_shiftReg = regs[pointer[4:0]];
              next_sdaOe = !regs[pointer[4:0]][7];
              next_bitCount = 4'h1;
            end
          end
        end
        default: begin
          next_state = RTCIA_IDLE;
          next_sdaOe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= RTCIA_IDLE;
      shiftReg <= 8'h00;
      bitCount <= 4'h0;
      byteIdx <= 2'h0;
      readMode <= 1'b0;
      nackPending <= 1'b0;
      pointer <= `RTCIA_PTR_RESET;
      sdaOe <= 1'b0;
      busBusy <= 1'b0;
      wrValid <= 1'b0;
      wrData <= 16'h0000;
    end else begin
      state <= next_state;
      shiftReg <= next_shiftReg;
      bitCount <= next_bitCount;
      byteIdx <= next_byteIdx;
      readMode <= next_readMode;
      nackPending <= next_nackPending;
      pointer <= next_pointer;
      sdaOe <= next_sdaOe;
      busBusy <= next_busBusy;
      wrValid <= next_wrValid;
      wrData <= next_wrData;
    end
  end

  // Register store; out-of-map addresses are dropped
  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs[i] <= 8'h00;
      end
    end else if (fifoOutValid && fifoOutData[15:8] <= `RTCIA_REG_TOP) begin
      regs[fifoOutData[12:8]] <= fifoOutData[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sdaOut <= 1'b0;
      regPointer <= `RTCIA_PTR_RESET;
    end else begin
      sdaOut <= 1'b0;
      regPointer <= pointer;
    end
  end
endmodule

// File: common/rtcia_defs.svh
/*
  Constants of the two-wire register access slave: bus identifier, map size, FIFO shape.
  Assumes inclusion by bare name from design files.
*/
`ifndef RTCIA_DEFS_SVH
`define RTCIA_DEFS_SVH
// Arbitrary bus identifier; boards override it
`define RTCIA_DEV_ID 7'h35
`define RTCIA_REG_TOP 8'h13
`define RTCIA_REG_COUNT 20
`define RTCIA_PTR_RESET 8'h00
`define RTCIA_FIFO_DEPTH 4
`define RTCIA_FIFO_WIDTH 16
`endif

// File: common/rtcia_pkg.sv
/*
  Types of the two-wire register access slave.
  Assumes nothing of its surroundings.
*/
package rtcia_pkg;
  typedef logic [7:0] rtcia_byte_t;
  typedef enum logic [2:0] {
    RTCIA_IDLE = 3'b000,
    RTCIA_RECV = 3'b001,
    RTCIA_ACK = 3'b010,
    RTCIA_SEND = 3'b011,
    RTCIA_MACK = 3'b100,
    RTCIA_IGNORE = 3'b101
  } rtcia_state_t;
endpackage

// File: common/rtcia_wr_if.sv
/*
  Write stream between the bus slave and its write FIFO.
  Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
interface rtcia_wr_if #(parameter int WIDTH = 16);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// File: src/rtcia_fifo.sv
/*
  Small valid/ready FIFO, parameterised in width and depth.
  Assumes one clock, synchronous active-high reset, depth a power of two.
*/
`timescale 1ns/1ps
module rtcia_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clock,
  input wire logic reset,
  rtcia_wr_if.sink inPort,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr, rdPtr, next_wrPtr, next_rdPtr;
  logic full, empty, doWrite, doRead;

  always_comb begin
    full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
    empty = (wrPtr == rdPtr);
    inPort.ready = !full;
    outValid = !empty;
    outData = mem[rdPtr[AW-1:0]];
    doWrite = inPort.valid && !full;
    doRead = outReady && !empty;
    next_wrPtr = doWrite ? wrPtr + 1'b1 : wrPtr;
    next_rdPtr = doRead ? rdPtr + 1'b1 : rdPtr;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      wrPtr <= next_wrPtr;
      rdPtr <= next_rdPtr;
    end
    if (doWrite) begin
      mem[wrPtr[AW-1:0]] <= inPort.data;
    end
  end
endmodule

// File: tb/rtcia_assertions.sv
/*
  Port checker for the two-wire register access slave.
  Assumes binding onto rtcia_slave, one clock, sync reset.
*/
`timescale 1ns/1ps
module rtcia_checker #(
  parameter int REG_COUNT = 20
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [7:0] regPointer,
  input wire logic busBusy
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_drive_low: assert property (!sdaOut)
    else $error("data drive value not zero");
  a_reset_clear: assert property ($fell(reset) |-> regPointer == 8'h00 && !busBusy && !sdaOe)
    else $error("outputs not cleared by reset");
  a_ptr_range: assert property (regPointer < REG_COUNT)
    else $error("pointer beyond top register");
  a_ptr_quiet: assert property (!busBusy && !$past(busBusy, 8) |-> $stable(regPointer))
    else $error("pointer moved with bus idle");
  a_ack_timing: assert property ($rose(sdaOe) |-> !sclIn && !$past(sclIn, 2) && $past(sclIn, 6))
    else $error("pull-down not started after clock fall");
  a_oe_in_low: assert property ($changed(sdaOe) |-> !sclIn && !$past(sclIn))
    else $error("data drive changed while clock high");
  a_start_seen: assert property ($rose(busBusy) |-> sclIn && !sdaIn)
    else $error("busy without start condition");
  a_stop_idle: assert property ($fell(busBusy) |-> sclIn && sdaIn)
    else $error("busy dropped without stop condition");
  a_idle_quiet: assert property (!busBusy |-> !sdaOe)
    else $error("data line pulled while idle");
  c_ack: cover property ($rose(sdaOe));
  c_wrap: cover property (regPointer == 8'h13 ##[1:1000] regPointer == 8'h00);
  c_done: cover property ($fell(busBusy));
endmodule
bind rtcia_slave rtcia_checker #(.REG_COUNT(REG_COUNT)) rtcia_checker_i (.clock(clock), .reset(reset),
  .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .regPointer(regPointer), .busBusy(busBusy));

// File: tb/rtcia_master.sv
/*
  Bus master model: start, stop, bytes out and in.
  Assumes the bench resolves the pulled-up data wire.
*/
`timescale 1ns/1ps
module rtcia_master (
  output logic scl,
  output logic sda,
  input wire logic sdaBus
);
  // Clock stands high between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic bitx(input logic b, output logic r);
    #31.25 sda = b;
    #31.25 scl = 1'b1;
    #31.25 r = sdaBus;
    #31.25 scl = 1'b0;
  endtask
  task automatic start();
    #31.25 sda = 1'b1;
    #31.25 scl = 1'b1;
    #62.5 sda = 1'b0;
    #62.5 scl = 1'b0;
  endtask
  task automatic stop();
    #31.25 sda = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 sda = 1'b1;
    #62.5;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic recv(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(!mack, r);
  endtask
endmodule

// File: tb/rtc_i2c_register_access_tb.sv
/*
  Self-checking bench for the two-wire register access slave.
  Assumes the master model and the bound checker.
*/
`timescale 1ns/1ps
module rtc_i2c_register_access_tb;
  localparam logic [6:0] DEV_ID = 7'h2a; // Arbitrary bus identifier
  logic clock;
  logic reset;
  logic scl;
  logic mSda;
  logic sdaBus;
  logic sdaOut;
  logic sdaOe;
  logic [7:0] regPointer;
  logic busBusy;
  logic [7:0] shadow [20];
  int miscompares = 0;
  int n_tests = 0;
  integer seed = 32'hb598aa9e;
  // Pull-up wins unless a party pulls low
  assign sdaBus = mSda & ~sdaOe;
  rtcia_slave #(.DEV_ID(DEV_ID)) rtcia_slave_i (.clock(clock), .reset(reset), .sclIn(scl), .sdaIn(sdaBus),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .regPointer(regPointer), .busBusy(busBusy));
  rtcia_master rtcia_master_i (.scl(scl), .sda(mSda), .sdaBus(sdaBus));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  function automatic logic [7:0] nextPtr(input logic [7:0] p);
    return (p == 8'h13) ? 8'h00 : p + 8'h01;
  endfunction
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] b, input logic expAck);
    logic ack;
    rtcia_master_i.send(b, ack);
    chk("ack", {7'h00, expAck}, {7'h00, ack});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rtcia_master_i.start();
    put({DEV_ID, 1'b0}, 1'b1);
    put(a, 1'b1);
    put(d, 1'b1);
    rtcia_master_i.stop();
    shadow[a] = d;
    chk("busy after stop", 8'h00, {7'h00, busBusy});
    chk("pointer after write", nextPtr(a), regPointer);
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    logic [7:0] d;
    logic [7:0] p;
    p = a;
    rtcia_master_i.start();
    put({DEV_ID, 1'b0}, 1'b1);
    put(a, 1'b1);
    rtcia_master_i.start();
    put({DEV_ID, 1'b1}, 1'b1);
    for (int i = 0; i < n; i++) begin
      rtcia_master_i.recv(i < n - 1, d);
      chk("read data", shadow[p], d);
      p = nextPtr(p);
    end
    rtcia_master_i.stop();
    chk("pointer after read", p, regPointer);
  endtask
  initial begin
    #500000;
    miscompares++;
    results();
  end
  initial begin
    logic [7:0] d;
    reset = 1'b1;
    foreach (shadow[i]) shadow[i] = 8'h00;
    repeat (2) @(posedge clock);
    #1 reset = 1'b0;
    repeat (3) @(posedge clock);
    // Off the clock grid, so bus edges never race a sampling edge
    #1;
    chk("pointer at reset", 8'h00, regPointer);
    rtcia_master_i.start();
    put({DEV_ID, 1'b1}, 1'b1);
    rtcia_master_i.recv(1'b0, d);
    rtcia_master_i.stop();
    chk("current address read", 8'h00, d);
    chk("pointer", 8'h01, regPointer);
    $display("test current read done");
    for (int i = 0; i < 20; i++) wr(8'(i), 8'($random(seed)));
    $display("test writes done");
    rd(8'h12, 23);
    rd(8'({$random(seed)} % 20), 3);
    $display("test reads done");
    rtcia_master_i.start();
    put({DEV_ID ^ 7'h01, 1'b0}, 1'b0);
    put(8'h05, 1'b0);
    rtcia_master_i.stop();
    rd(8'h05, 1);
    d = 8'($random(seed));
    rtcia_master_i.start();
    put({DEV_ID, 1'b0}, 1'b1);
    put(8'h09, 1'b1);
    put(d, 1'b1);
    put(~d, 1'b0);
    rtcia_master_i.stop();
    shadow[9] = d;
    chk("pointer after long write", 8'h0a, regPointer);
    rd(8'h09, 1);
    $display("test wrong id done");
    rtcia_master_i.start();
    put({DEV_ID, 1'b0}, 1'b1);
    put(8'h07, 1'b1);
    @(posedge clock);
    #1 reset = 1'b1;
    repeat (2) @(posedge clock);
    #1 reset = 1'b0;
    chk("pointer after reset", 8'h00, regPointer);
    rtcia_master_i.stop();
    foreach (shadow[i]) shadow[i] = 8'h00;
    rd(8'h13, 2);
    $display("test mid reset done");
    results();
  end
endmodule
